/* File: ssmq_pkg.sv */
// Purpose: Shared constants and types for the speed monitor stop/start sequencer.
// Assumes: 200 MHz clock; register port with one-cycle read latency.
// Notes: Timing counts are derived from their printed times.
package ssmq_pkg;
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned WINDOW_S = 5;
    localparam longint unsigned WINDOW_CYC = longint'(WINDOW_S) * longint'(CLK_HZ);
    localparam int unsigned READY_MS = 200;
    localparam longint unsigned READY_CYC = longint'(READY_MS) * longint'(CLK_HZ) / 64'd1000;
    localparam int unsigned CNT_W = 32;
    localparam int unsigned SPEED_W = 16;

    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STAT = 4'h1;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h2;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
    localparam logic [3:0] ADDR_LIMIT = 4'h4;

    localparam int unsigned CTRL_EXT_EN = 0;
    localparam int unsigned CTRL_KEEP = 1;

    localparam int unsigned EV_TIMEOUT = 0;
    localparam int unsigned EV_STOPPED = 1;
    localparam int unsigned EV_W = 2;
    localparam logic [15:0] LIMIT_RST = 16'h0000;

    typedef enum logic [2:0] {
        ST_OFF, ST_RUN, ST_RAMP, ST_TORQUE_OFF, ST_ARMED, ST_LOCKED
    } ssmq_state_type;

    typedef struct packed {
        logic run_request_bit;
        logic coast_stop_bit;
        logic quick_ramp_stop_command;
        logic torque_off_deselect_flag;
    } ssmq_cmd_type;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } ssmq_bus_type;
endpackage : ssmq_pkg

/* File: ssmq_timer.sv */
// Purpose: Down-counting window timer with restart and clear.
// Assumes: Synchronous active-low reset.
// Notes: Expiry is a one-cycle pulse when the count steps from one to zero.
`timescale 1ns/1ps
module ssmq_timer #(
    parameter int unsigned W = 32
) (
    input wire logic clk_in, // Clock.
    input wire logic rst_b_in, // Reset, active low.
    input wire logic start_in, // Load the count and run.
    input wire logic clear_in, // Stop the timer.
    input wire logic [W-1:0] load_in, // Count to load.
    output logic expire_out // One-cycle expiry pulse.
);
    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;
    logic exp_ff;
    logic nxt_exp;

    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_exp = 1'b0;
        if (start_in) begin
            nxt_cnt = load_in;
        end else if (clear_in) begin
            nxt_cnt = '0;
        end else if (cnt_ff != '0) begin
            nxt_cnt = cnt_ff - 1'b1;
            nxt_exp = (cnt_ff == {{(W-1){1'b0}}, 1'b1});
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            cnt_ff <= '0;
            exp_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            exp_ff <= nxt_exp;
        end
    end

    assign expire_out = exp_ff;
endmodule : ssmq_timer

/* File: ssmq_cmp.sv */
// Purpose: Registered speed against limit comparison.
// Assumes: Speed is an unsigned magnitude.
// Notes: Result lags the speed input by one cycle.
`timescale 1ns/1ps
module ssmq_cmp #(
    parameter int unsigned W = 16
) (
    input wire logic clk_in, // Clock.
    input wire logic rst_b_in, // Reset, active low.
    input wire logic [W-1:0] speed_in, // Measured speed.
    input wire logic [W-1:0] limit_in, // Monitor limit.
    output logic below_out // Speed below limit.
);
    logic below_ff;
    logic nxt_below;

    always_comb begin
        nxt_below = (speed_in < limit_in);
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            below_ff <= 1'b0;
        end else begin
            below_ff <= nxt_below;
        end
    end

    assign below_out = below_ff;
endmodule : ssmq_cmp

/* File: ssmq_seq.sv */
// What this block does
// - Kept setting: torque-off on switch-off, monitor status held at 1.
// - Dropped setting: monitor status cleared to 0 on switch-off.
// - Ramp or quick ramp stop decelerates to standstill, then switches off.
// - Speed compared against limit during the ramp deceleration.
// - Coast stop switches off at once, no deceleration.
// - Coast stop above limit keeps below-limit feedback at 0.
// - Dropped setting accepts run request directly; monitor active when running.
// - No run request within 5 s: return to torque-off.
// - After timeout, run requests ignored until full sequence repeated.
// - Window expiry raises a switch-on timeout alarm.
// - Below-limit feedback is 0 after power-up.
// - Monitor active when extended functions enabled and limit above zero.
//
// Purpose: Switch-off and switch-on sequencer of the speed threshold monitor.
// Assumes: Commands and speed are synchronous; register reads answer next cycle.
// Notes: Window length is a parameter so simulation can shorten it.
`timescale 1ns/1ps
module ssmq_seq #(
    parameter longint unsigned WINDOW_CYCLES = ssmq_pkg::WINDOW_CYC,
    parameter longint unsigned READY_CYCLES = ssmq_pkg::READY_CYC,
    parameter int unsigned SPEED_W = ssmq_pkg::SPEED_W
) (
    input wire logic clk_in, // Clock, 200 MHz.
    input wire logic rst_b_in, // Synchronous reset, active low.
    input wire ssmq_pkg::ssmq_cmd_type cmd_in, // Command bits from the controller.
    input wire logic [SPEED_W-1:0] speed_in, // Measured motor speed.
    input wire logic standstill_in, // Motor has reached standstill.
    input wire ssmq_pkg::ssmq_bus_type bus_in, // Register port request.
    output logic [15:0] rdata_out, // Read data, one cycle after the strobe.
    output logic motor_on_out, // Pulses enabled.
    output logic decel_out, // Ramp deceleration in progress.
    output logic safe_torque_off_out, // Torque-off active flag.
    output logic below_limit_feedback_flag_out, // Speed below limit.
    output logic monitor_status_out, // Monitor status.
    output logic ready_to_switch_on_flag_out, // Ready to switch on.
    output logic switch_on_timeout_alarm_out, // Switch-on timeout alarm.
    output logic irq_out // Interrupt, high while an unmasked event is pending.
);
    ssmq_pkg::ssmq_state_type state_ff, nxt_state;
    logic [1:0] ctrl_ff, nxt_ctrl;
    logic [SPEED_W-1:0] limit_ff, nxt_limit;
    logic [ssmq_pkg::EV_W-1:0] ist_ff, nxt_ist, imask_ff, nxt_imask;
    logic [15:0] rdata_ff, nxt_rdata;
    logic on_ff, nxt_on, dec_ff, nxt_dec, sto_ff, nxt_sto, fb_ff, nxt_fb;
    logic stat_ff, nxt_stat, rdy_ff, nxt_rdy, alarm_ff, nxt_alarm, irq_ff, nxt_irq;
    logic deselect_ff, nxt_deselect;
    logic [ssmq_pkg::CNT_W-1:0] rdy_cnt_ff, nxt_rdy_cnt;
    logic below, win_expire, win_start, win_clear, active, keep, run_req, deselect_rise;
    logic [ssmq_pkg::EV_W-1:0] ev;

    ssmq_cmp #(.W(SPEED_W)) u_cmp (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .speed_in(speed_in),
        .limit_in(limit_ff),
        .below_out(below)
    );

    ssmq_timer #(.W(ssmq_pkg::CNT_W)) u_win (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .start_in(win_start),
        .clear_in(win_clear),
        .load_in(ssmq_pkg::CNT_W'(WINDOW_CYCLES)),
        .expire_out(win_expire)
    );

    assign keep = ctrl_ff[ssmq_pkg::CTRL_KEEP];
    assign active = ctrl_ff[ssmq_pkg::CTRL_EXT_EN] && (limit_ff != '0);
    assign run_req = cmd_in.run_request_bit && !cmd_in.coast_stop_bit && !cmd_in.quick_ramp_stop_command;
    assign deselect_rise = cmd_in.torque_off_deselect_flag && !deselect_ff;

    // Sequencer: deselection restarts the window, an accepted run clears it.
    always_comb begin
        nxt_state = state_ff;
        nxt_deselect = cmd_in.torque_off_deselect_flag;
        win_start = 1'b0;
        win_clear = 1'b0;
        nxt_alarm = alarm_ff;
        ev = '0;
        case (state_ff)
            ssmq_pkg::ST_OFF: begin
                if (active && keep) begin
                    nxt_state = ssmq_pkg::ST_TORQUE_OFF;
                end else if (run_req) begin
                    nxt_state = ssmq_pkg::ST_RUN;
                end
            end
            ssmq_pkg::ST_RUN: begin
                if (cmd_in.coast_stop_bit) begin
                    ev[ssmq_pkg::EV_STOPPED] = 1'b1;
                    nxt_state = (active && keep) ? ssmq_pkg::ST_TORQUE_OFF : ssmq_pkg::ST_OFF;
                end else if (!cmd_in.run_request_bit || cmd_in.quick_ramp_stop_command) begin
                    nxt_state = ssmq_pkg::ST_RAMP;
                end
            end
            ssmq_pkg::ST_RAMP: begin
                if (cmd_in.coast_stop_bit || standstill_in) begin
                    ev[ssmq_pkg::EV_STOPPED] = 1'b1;
                    nxt_state = (active && keep) ? ssmq_pkg::ST_TORQUE_OFF : ssmq_pkg::ST_OFF;
                end
            end
            ssmq_pkg::ST_TORQUE_OFF, ssmq_pkg::ST_LOCKED: begin
                // Only a fresh select-then-deselect reopens the window.
                if (!active || !keep) begin
                    nxt_state = ssmq_pkg::ST_OFF;
                end else if (deselect_rise) begin
                    win_start = 1'b1;
                    nxt_alarm = 1'b0;
                    nxt_state = ssmq_pkg::ST_ARMED;
                end
            end
            ssmq_pkg::ST_ARMED: begin
                if (!cmd_in.torque_off_deselect_flag) begin
                    win_clear = 1'b1;
                    nxt_state = ssmq_pkg::ST_TORQUE_OFF;
                end else if (win_expire) begin
                    nxt_alarm = 1'b1;
                    ev[ssmq_pkg::EV_TIMEOUT] = 1'b1;
                    nxt_state = ssmq_pkg::ST_LOCKED;
                end else if (run_req) begin
                    win_clear = 1'b1;
                    nxt_state = ssmq_pkg::ST_RUN;
                end
            end
            default: begin
                nxt_state = ssmq_pkg::ST_OFF;
            end
        endcase
    end

    // Ready indication: at once in the off state, else after the settle delay following deselection.
    always_comb begin
        nxt_rdy_cnt = rdy_cnt_ff;
        if (nxt_state != ssmq_pkg::ST_ARMED) begin
            nxt_rdy_cnt = '0;
        end else if (rdy_cnt_ff != ssmq_pkg::CNT_W'(READY_CYCLES)) begin
            nxt_rdy_cnt = rdy_cnt_ff + 1'b1;
        end
        nxt_rdy = (nxt_state == ssmq_pkg::ST_OFF)
            || ((nxt_state == ssmq_pkg::ST_ARMED) && (rdy_cnt_ff == ssmq_pkg::CNT_W'(READY_CYCLES)));
    end

    // Outputs derived from the next state so they are all registered.
    always_comb begin
        nxt_on = (nxt_state == ssmq_pkg::ST_RUN) || (nxt_state == ssmq_pkg::ST_RAMP);
        nxt_dec = (nxt_state == ssmq_pkg::ST_RAMP);
        nxt_sto = (nxt_state == ssmq_pkg::ST_TORQUE_OFF) || (nxt_state == ssmq_pkg::ST_LOCKED)
            || (nxt_state == ssmq_pkg::ST_ARMED);
        // Comparison continues while ramping; after switch-off the kept setting freezes the last result, the dropped one clears it.
        if (!active) begin
            nxt_fb = 1'b0;
        end else if (nxt_on) begin
            nxt_fb = below;
        end else if (keep) begin
            nxt_fb = fb_ff;
        end else begin
            nxt_fb = 1'b0;
        end
        if (!active) begin
            nxt_stat = 1'b0;
        end else if (nxt_on) begin
            nxt_stat = 1'b1;
        end else begin
            nxt_stat = keep;
        end
    end

    // Register port and interrupt status.
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_limit = limit_ff;
        nxt_imask = imask_ff;
        nxt_ist = ist_ff;
        nxt_rdata = '0;
        if (bus_in.wr) begin
            case (bus_in.addr)
                ssmq_pkg::ADDR_CTRL: nxt_ctrl = bus_in.wdata[1:0];
                ssmq_pkg::ADDR_LIMIT: nxt_limit = bus_in.wdata[SPEED_W-1:0];
                ssmq_pkg::ADDR_IRQ_MASK: nxt_imask = bus_in.wdata[ssmq_pkg::EV_W-1:0];
                ssmq_pkg::ADDR_IRQ_STAT: nxt_ist = ist_ff & ~bus_in.wdata[ssmq_pkg::EV_W-1:0];
                default: nxt_ctrl = ctrl_ff;
            endcase
        end
        nxt_ist = nxt_ist | ev;
        if (bus_in.rd) begin
            case (bus_in.addr)
                ssmq_pkg::ADDR_CTRL: nxt_rdata = {14'h0000, ctrl_ff};
                ssmq_pkg::ADDR_STAT: nxt_rdata = {9'h000, alarm_ff, rdy_ff, stat_ff, fb_ff, sto_ff, dec_ff, on_ff};
                ssmq_pkg::ADDR_IRQ_STAT: nxt_rdata = {14'h0000, ist_ff};
                ssmq_pkg::ADDR_IRQ_MASK: nxt_rdata = {14'h0000, imask_ff};
                ssmq_pkg::ADDR_LIMIT: nxt_rdata = 16'(limit_ff);
                default: nxt_rdata = '0;
            endcase
        end
        nxt_irq = |(nxt_ist & nxt_imask);
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            state_ff <= ssmq_pkg::ST_OFF;
            deselect_ff <= 1'b0;
            ctrl_ff <= '0;
            limit_ff <= ssmq_pkg::LIMIT_RST[SPEED_W-1:0];
            imask_ff <= '0;
            ist_ff <= '0;
            rdata_ff <= '0;
            on_ff <= 1'b0;
            dec_ff <= 1'b0;
            sto_ff <= 1'b0;
            fb_ff <= 1'b0;
            stat_ff <= 1'b0;
            rdy_ff <= 1'b0;
            alarm_ff <= 1'b0;
            irq_ff <= 1'b0;
            rdy_cnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            deselect_ff <= nxt_deselect;
            ctrl_ff <= nxt_ctrl;
            limit_ff <= nxt_limit;
            imask_ff <= nxt_imask;
            ist_ff <= nxt_ist;
            rdata_ff <= nxt_rdata;
            on_ff <= nxt_on;
            dec_ff <= nxt_dec;
            sto_ff <= nxt_sto;
            fb_ff <= nxt_fb;
            stat_ff <= nxt_stat;
            rdy_ff <= nxt_rdy;
            alarm_ff <= nxt_alarm;
            irq_ff <= nxt_irq;
            rdy_cnt_ff <= nxt_rdy_cnt;
        end
    end

    assign rdata_out = rdata_ff;
    assign motor_on_out = on_ff;
    assign decel_out = dec_ff;
    assign safe_torque_off_out = sto_ff;
    assign below_limit_feedback_flag_out = fb_ff;
    assign monitor_status_out = stat_ff;
    assign ready_to_switch_on_flag_out = rdy_ff;
    assign switch_on_timeout_alarm_out = alarm_ff;
    assign irq_out = irq_ff;

    property p_keep_sto;
        @(posedge clk_in) disable iff (!rst_b_in)
        (active && keep && !on_ff) |=> (sto_ff || on_ff);
    endproperty
    a_keep_sto: assert property (p_keep_sto) else $error("Motor off without torque-off.");
    property p_off_keep;
        @(posedge clk_in) disable iff (!rst_b_in)
        ($fell(on_ff) && active && keep) |-> (sto_ff && stat_ff);
    endproperty
    a_off_keep: assert property (p_off_keep) else $error("Kept setting did not force torque-off.");
    property p_off_drop;
        @(posedge clk_in) disable iff (!rst_b_in)
        ($fell(on_ff) && !keep) |-> !stat_ff;
    endproperty
    a_off_drop: assert property (p_off_drop) else $error("Dropped setting kept monitor status.");
    property p_ramp;
        @(posedge clk_in) disable iff (!rst_b_in)
        (dec_ff && !standstill_in && !cmd_in.coast_stop_bit) |=> on_ff;
    endproperty
    a_ramp: assert property (p_ramp) else $error("Motor switched off before standstill.");
    property p_track;
        @(posedge clk_in) disable iff (!rst_b_in)
        (dec_ff && active && $past(dec_ff)) |-> (fb_ff == $past(below));
    endproperty
    a_track: assert property (p_track) else $error("Speed not compared during ramp.");
    property p_coast;
        @(posedge clk_in) disable iff (!rst_b_in)
        (on_ff && cmd_in.coast_stop_bit) |=> !on_ff;
    endproperty
    a_coast: assert property (p_coast) else $error("Coast stop did not switch off at once.");
    property p_timeout;
        @(posedge clk_in) disable iff (!rst_b_in)
        (state_ff == ssmq_pkg::ST_ARMED && win_expire && cmd_in.torque_off_deselect_flag)
            |=> (alarm_ff && sto_ff && state_ff == ssmq_pkg::ST_LOCKED);
    endproperty
    a_timeout: assert property (p_timeout) else $error("Window expiry not handled.");
    property p_locked;
        @(posedge clk_in) disable iff (!rst_b_in)
        (state_ff == ssmq_pkg::ST_LOCKED) |=> !on_ff;
    endproperty
    a_locked: assert property (p_locked) else $error("Run accepted after timeout.");
    property p_irq;
        @(posedge clk_in) disable iff (!rst_b_in)
        $rose(alarm_ff) |-> ist_ff[ssmq_pkg::EV_TIMEOUT];
    endproperty
    a_irq: assert property (p_irq) else $error("Timeout alarm not latched.");
    property p_inactive;
        @(posedge clk_in) disable iff (!rst_b_in)
        !active |=> !fb_ff;
    endproperty
    a_inactive: assert property (p_inactive) else $error("Feedback set while monitor inactive.");
    property p_coast_fb;
        @(posedge clk_in) disable iff (!rst_b_in)
        (on_ff && cmd_in.coast_stop_bit && !fb_ff) |=> !fb_ff;
    endproperty
    a_coast_fb: assert property (p_coast_fb) else $error("Feedback rose on coast stop.");
    property p_run_drop;
        @(posedge clk_in) disable iff (!rst_b_in)
        (state_ff == ssmq_pkg::ST_OFF && !keep && run_req) |=> on_ff;
    endproperty
    a_run_drop: assert property (p_run_drop) else $error("Run request refused with dropped setting.");
    property p_run_status;
        @(posedge clk_in) disable iff (!rst_b_in)
        (on_ff && $past(active)) |-> stat_ff;
    endproperty
    a_run_status: assert property (p_run_status) else $error("Monitor status low while running.");
    property p_pwrup;
        @(posedge clk_in) disable iff (!rst_b_in)
        $rose(rst_b_in) |-> (!fb_ff && !stat_ff);
    endproperty
    a_pwrup: assert property (p_pwrup) else $error("Feedback not cleared by reset.");
    property p_reopen;
        @(posedge clk_in) disable iff (!rst_b_in)
        (state_ff == ssmq_pkg::ST_LOCKED && deselect_rise && active && keep)
            |=> (state_ff == ssmq_pkg::ST_ARMED && sto_ff && !alarm_ff);
    endproperty
    a_reopen: assert property (p_reopen) else $error("Full sequence did not reopen the window.");
    property p_run_clear;
        @(posedge clk_in) disable iff (!rst_b_in)
        (state_ff == ssmq_pkg::ST_ARMED && cmd_in.torque_off_deselect_flag && !win_expire && run_req)
            |=> (on_ff && !win_expire);
    endproperty
    a_run_clear: assert property (p_run_clear) else $error("Accepted run did not stop the window.");
    property p_stop_irq;
        @(posedge clk_in) disable iff (!rst_b_in)
        $fell(on_ff) |-> ist_ff[ssmq_pkg::EV_STOPPED];
    endproperty
    a_stop_irq: assert property (p_stop_irq) else $error("Switch-off event not latched.");
    property p_alarm_sticky;
        @(posedge clk_in) disable iff (!rst_b_in)
        (alarm_ff && !deselect_rise) |=> alarm_ff;
    endproperty
    a_alarm_sticky: assert property (p_alarm_sticky) else $error("Timeout alarm dropped early.");
endmodule : ssmq_seq

/* File: ssmq_ctl.sv */
// Purpose: Behavioural higher-level controller that drives the command bits.
// Assumes: Commands are levels, changed just after a rising edge.
// Notes: The model never switches on late by itself; the bench decides that by not calling switch_on.
`timescale 1ns/1ps
module ssmq_ctl (
    input wire logic clk_in, // Clock.
    input wire logic ready_in, // Ready-to-switch-on flag from the device.
    output ssmq_pkg::ssmq_cmd_type cmd_out // Command bits to the device.
);
    initial begin
        cmd_out = '0;
    end

    task automatic put(input logic run, input logic coast, input logic quick, input logic desel);
        @(posedge clk_in);
        cmd_out <= '{run, coast, quick, desel};
    endtask : put

    // Torque-off is selected only with the motor already off, then deselected again.
    task automatic arm();
        put(1'b0, 1'b0, 1'b0, 1'b0);
        repeat (2) @(posedge clk_in);
        put(1'b0, 1'b0, 1'b0, 1'b1);
    endtask : arm

    // Waits for ready, bounded well inside the switch-on window, then requests the run.
    task automatic switch_on();
        int n;
        n = 0;
        do begin
            @(negedge clk_in);
            n++;
        end while (ready_in !== 1'b1 && n < 40);
        if (ready_in !== 1'b1) begin
            tb_ssmq_seq.fail_count++;
            tb_ssmq_seq.summarize();
        end
        put(1'b1, 1'b0, 1'b0, 1'b1);
    endtask : switch_on
endmodule : ssmq_ctl

/* File: tb_ssmq_seq.sv */
// Purpose: Self-checking bench for the speed monitor stop/start sequencer.
// Assumes: Switch-on window shortened to 50 cycles and ready delay to 5 cycles.
// Notes: Outputs are sampled on the falling edge, so every drive of the rising edge has landed.
`timescale 1ns/1ps
module tb_ssmq_seq;
    localparam logic [6:0] B_ON = 7'h01;
    localparam logic [6:0] B_DEC = 7'h02;
    localparam logic [6:0] B_STO = 7'h04;
    localparam logic [6:0] B_FB = 7'h08;
    localparam logic [6:0] B_MS = 7'h10;
    localparam logic [6:0] B_ALM = 7'h40;
    localparam logic [6:0] B_RDY = 7'h20;
    localparam int WIN_CYC = 50;
    localparam int RDY_CYC = 5;
    logic clk_in;
    logic rst_b_in;
    logic [15:0] speed;
    logic standstill;
    ssmq_pkg::ssmq_bus_type bus;
    ssmq_pkg::ssmq_cmd_type cmd;
    logic [15:0] rdata;
    logic on, decel, safe_torque_off, fb, mstat, ready, alarm, irq;
    logic [6:0] st;
    int fail_count;
    int n_checks;
    int n;

    assign st = {alarm, ready, mstat, fb, safe_torque_off, decel, on};

    ssmq_seq #(.WINDOW_CYCLES(WIN_CYC), .READY_CYCLES(RDY_CYC)) u_dut (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .cmd_in(cmd), .speed_in(speed),
        .standstill_in(standstill), .bus_in(bus), .rdata_out(rdata), .motor_on_out(on),
        .decel_out(decel), .safe_torque_off_out(safe_torque_off), .below_limit_feedback_flag_out(fb),
        .monitor_status_out(mstat), .ready_to_switch_on_flag_out(ready),
        .switch_on_timeout_alarm_out(alarm), .irq_out(irq));

    ssmq_ctl u_ctl (.clk_in(clk_in), .ready_in(ready), .cmd_out(cmd));

    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    task automatic summarize();
        $display("Checks: %0d, mismatches: %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chks(input logic [6:0] m, input logic [6:0] e);
        chk({9'h000, st & m}, {9'h000, e});
    endtask : chks

    task automatic w(input int c);
        repeat (c) @(posedge clk_in);
        @(negedge clk_in);
    endtask : w

    task automatic drv(input logic [15:0] s, input logic ss);
        @(posedge clk_in);
        speed <= s;
        standstill <= ss;
    endtask : drv

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_in);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk_in);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rdc(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_in);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk_in);
        bus.rd <= 1'b0;
        @(negedge clk_in);
        chk(rdata, e);
    endtask : rdc

    initial begin
        repeat (20000) @(posedge clk_in);
        fail_count++;
        summarize();
    end

    initial begin
        rst_b_in = 1'b0;
        speed = 16'h0000;
        standstill = 1'b0;
        bus = '0;
        fail_count = 0;
        n_checks = 0;
        repeat (3) @(posedge clk_in);
        rst_b_in <= 1'b1;
        w(1);
        chks(7'h7f, B_RDY);
        rdc(ssmq_pkg::ADDR_STAT, {9'h000, B_RDY});
        rdc(4'hf, 16'h0000);
        wr(ssmq_pkg::ADDR_LIMIT, 16'h0064);
        wr(ssmq_pkg::ADDR_CTRL, 16'h0001);
        rdc(ssmq_pkg::ADDR_CTRL, 16'h0001);
        // Feedback tracked during the ramp: run, ramp stop with a speed excursion.
        drv(16'h0032, 1'b0);
        u_ctl.put(1'b1, 1'b0, 1'b0, 1'b0);
        w(1);
        chks(B_ON | B_MS | B_DEC | B_STO, B_ON | B_MS);
        w(3);
        chks(B_FB, B_FB);
        u_ctl.put(1'b0, 1'b0, 1'b0, 1'b0);
        w(1);
        chks(B_ON | B_DEC, B_ON | B_DEC);
        drv(16'h0096, 1'b0);
        w(3);
        chks(B_ON | B_FB, B_ON);
        drv(16'h0000, 1'b1);
        w(1);
        chks(B_ON | B_DEC | B_MS | B_STO, 7'h00);
        drv(16'h0000, 1'b0);
        rdc(ssmq_pkg::ADDR_IRQ_STAT, 16'h0002);
        chk(16'(irq), 16'h0000);
        wr(ssmq_pkg::ADDR_IRQ_MASK, 16'h0002);
        w(2);
        chk(16'(irq), 16'h0001);
        wr(ssmq_pkg::ADDR_IRQ_STAT, 16'h0002);
        w(2);
        chk(16'(irq), 16'h0000);
        // Quick ramp stop, then coast stop above the limit.
        u_ctl.put(1'b1, 1'b0, 1'b0, 1'b0);
        w(1);
        u_ctl.put(1'b1, 1'b0, 1'b1, 1'b0);
        w(1);
        chks(B_ON | B_DEC, B_ON | B_DEC);
        drv(16'h0096, 1'b1);
        w(1);
        chks(B_ON | B_DEC, 7'h00);
        drv(16'h0096, 1'b0);
        u_ctl.put(1'b0, 1'b0, 1'b0, 1'b0);
        u_ctl.put(1'b1, 1'b0, 1'b0, 1'b0);
        w(3);
        chks(B_ON | B_FB, B_ON);
        u_ctl.put(1'b1, 1'b1, 1'b0, 1'b0);
        w(1);
        chks(B_ON | B_DEC | B_FB | B_MS, 7'h00);
        // Keep setting with a zero limit leaves the monitor inactive.
        u_ctl.put(1'b0, 1'b0, 1'b0, 1'b0);
        wr(ssmq_pkg::ADDR_LIMIT, 16'h0000);
        wr(ssmq_pkg::ADDR_CTRL, 16'h0003);
        u_ctl.put(1'b1, 1'b0, 1'b0, 1'b0);
        w(1);
        chks(B_ON | B_MS | B_STO, B_ON);
        u_ctl.put(1'b0, 1'b1, 1'b0, 1'b0);
        w(1);
        chks(B_ON | B_STO, 7'h00);
        u_ctl.put(1'b0, 1'b0, 1'b0, 1'b0);
        wr(ssmq_pkg::ADDR_LIMIT, 16'h0064);
        w(3);
        chks(B_ON | B_STO | B_MS, B_STO | B_MS);
        u_ctl.arm();
        w(RDY_CYC);
        chks(B_RDY | B_STO, B_STO);
        w(1);
        chks(B_RDY | B_STO, B_RDY | B_STO);
        u_ctl.switch_on();
        w(1);
        chks(B_ON | B_STO | B_MS, B_ON | B_MS);
        w(3);
        chks(B_FB, 7'h00);
        u_ctl.put(1'b1, 1'b1, 1'b0, 1'b1);
        w(1);
        chks(B_ON | B_STO | B_MS | B_FB, B_STO | B_MS);
        // Switch-on window runs out.
        wr(ssmq_pkg::ADDR_IRQ_STAT, 16'h0003);
        wr(ssmq_pkg::ADDR_IRQ_MASK, 16'h0001);
        u_ctl.arm();
        n = 0;
        while (alarm !== 1'b1 && n < 80) begin
            w(1);
            n++;
        end
        if (n == 80) begin
            fail_count++;
            summarize();
        end
        chk(16'(n), 16'(WIN_CYC + 2));
        chks(B_ALM | B_STO | B_ON, B_ALM | B_STO);
        w(2);
        chk(16'(irq), 16'h0001);
        u_ctl.put(1'b1, 1'b0, 1'b0, 1'b1);
        w(10);
        chks(B_ON, 7'h00);
        u_ctl.arm();
        u_ctl.switch_on();
        w(1);
        chks(B_ON | B_ALM, B_ON);
        // Reselecting restarts the window; an accepted run stops it.
        u_ctl.put(1'b0, 1'b1, 1'b0, 1'b1);
        u_ctl.arm();
        w(40);
        u_ctl.arm();
        w(40);
        chks(B_ALM | B_ON, 7'h00);
        u_ctl.switch_on();
        w(1);
        chks(B_ON, B_ON);
        w(60);
        chks(B_ALM | B_ON, B_ON);
        // A mid-run reset must clear feedback that was set while running.
        drv(16'h0032, 1'b0);
        w(3);
        chks(B_FB, B_FB);
        @(posedge clk_in);
        rst_b_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        rst_b_in <= 1'b1;
        w(1);
        chks(B_FB | B_MS | B_STO | B_ALM, 7'h00);
        summarize();
    end
endmodule : tb_ssmq_seq
